// ==== core/clock_ctrl_pkg.sv ====
// constants, register map and state codes for the clock control block
// assumes a byte-wide register port from the on-chip processor

package clock_ctrl_pkg;

  // ------------------------------------------------------------
  // register addresses and reset value
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SELECT = 8'hA9;
  localparam logic [7:0] ADDR_EXT_OSC = 8'hB1;
  localparam logic [7:0] ADDR_CLK_MULT = 8'hBE;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int XTAL_VALID_BIT = 7;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 6;
  localparam int FREQ_MSB = 2;
  localparam int MULT_EN_BIT = 7;
  localparam int MULT_INIT_BIT = 6;
  localparam int MULT_LOCK_BIT = 5;
  localparam int SEL_MSB = 1;

  // ------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;
  localparam logic [1:0] MULT_IN_INT_HALF = 2'h0;
  localparam logic [1:0] MULT_IN_EXT = 2'h1;
  localparam logic [1:0] MULT_IN_EXT_HALF = 2'h2;
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_MULT = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  localparam logic [1:0] DIV_BY_8 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_2 = 2'h2;

  // ------------------------------------------------------------
  // multiplier timing
  // ------------------------------------------------------------
  localparam int PERIOD_W = 8;
  localparam int MULT_SHIFT = 2;
  localparam logic [2:0] LOCK_PERIODS = 3'h4;

  // ------------------------------------------------------------
  // source switch states
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SW_RUN = 3'h1,
    SW_OLD = 3'h2,
    SW_NEW = 3'h4
  } sw_state_t;

endpackage

// ==== core/clock_ctrl.sv ====
// clock control: external oscillator mode, clock multiplier, system clock select
// assumes clock sources arrive as one-cycle enable pulses; the external
// oscillator and crystal-ok indication are pins from outside the domain
`timescale 1ns/100ps
`default_nettype none

module clock_ctrl
(
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata, // read data, one cycle after strobe
  input wire logic int_osc_tick, // internal oscillator pulse
  input wire logic [1:0] int_osc_divider_field, // internal divider code
  input wire logic ext_osc_pin, // external oscillator level
  input wire logic crystal_ok_pin, // amplitude detector level
  output logic [2:0] ext_osc_mode_field, // mode to drive circuit
  output logic [2:0] ext_drive_freq_code, // frequency code to drive circuit
  output logic sysclk_tick, // selected system clock pulse
  output logic periph_ext_tick, // external clock for timers
  output logic mult_tick // multiplier output pulse
);

  // ------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------
  function automatic logic mode_on(input logic [2:0] m);
    mode_on = (m[2:1] != 2'h0);
  endfunction

  function automatic logic mode_div2(input logic [2:0] m);
    mode_div2 = (m == clock_ctrl_pkg::MODE_CMOS_DIV2) || (m == clock_ctrl_pkg::MODE_XTAL_DIV2);
  endfunction

  function automatic logic src_tick(input logic [1:0] s, input logic ti, input logic te,
    input logic tm);
    src_tick = (s == clock_ctrl_pkg::SRC_INT) ? ti :
               (s == clock_ctrl_pkg::SRC_EXT) ? te :
               (s == clock_ctrl_pkg::SRC_MULT) ? tm : 1'b0;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [2:0] ext_sync, crys_sync;
  logic ext_lvl, crys_lvl, ext_half, ext_half2;
  logic [2:0] int_cnt;
  logic mult_en, mult_init, mult_locked, init_run;
  localparam int PERIOD_W_L = clock_ctrl_pkg::PERIOD_W;
  localparam logic [PERIOD_W_L-1:0] P_ONE = {{(PERIOD_W_L-1){1'b0}}, 1'b1}; // counter step
  logic [1:0] mult_sel, clk_sel, cur_sel, pend_sel;
  logic [PERIOD_W_L-1:0] since, period, out_cnt;
  logic [1:0] sub;
  logic [2:0] lock_cnt;
  clock_ctrl_pkg::sw_state_t sw_state;

  logic [2:0] next_ext_sync, next_crys_sync, next_mode, next_freq, next_int_cnt, next_lock_cnt;
  logic next_ext_lvl, next_crys_lvl, next_ext_half, next_ext_half2;
  logic next_en, next_init, next_locked, next_init_run, next_sys, next_periph, next_mtick;
  logic [1:0] next_msel, next_csel, next_cur, next_pend, next_sub;
  logic [PERIOD_W_L-1:0] next_since, next_period, next_out_cnt, quarter;
  logic [7:0] next_rdata;
  clock_ctrl_pkg::sw_state_t next_sw;
  logic ext_rise, ext_tick, int_sys, int_half, mi, stable, wr_ext, wr_mult, wr_sel;
  logic [2:0] div_mask;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // pin sync, dividers, registers, multiplier and switcher
  always_comb
  begin
    wr_ext = sfr_wr && (sfr_addr == clock_ctrl_pkg::ADDR_EXT_OSC);
    wr_mult = sfr_wr && (sfr_addr == clock_ctrl_pkg::ADDR_CLK_MULT);
    wr_sel = sfr_wr && (sfr_addr == clock_ctrl_pkg::ADDR_CLK_SELECT);
    // three-stage pin sync; a change counts when stages two and three agree
    next_ext_sync = {ext_sync[1:0], ext_osc_pin};
    next_crys_sync = {crys_sync[1:0], crystal_ok_pin};
    next_ext_lvl = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_lvl;
    next_crys_lvl = (crys_sync[1] == crys_sync[2]) ? crys_sync[2] : crys_lvl;
    ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_lvl;
    // external source with optional divide by two
    next_ext_half = ext_half;
    if (ext_rise && mode_on(ext_osc_mode_field))
      next_ext_half = !ext_half;
    ext_tick = ext_rise && mode_on(ext_osc_mode_field) &&
               (!mode_div2(ext_osc_mode_field) || ext_half);
    next_ext_half2 = ext_tick ? !ext_half2 : ext_half2;
    next_periph = ext_tick;
    // internal divider
    unique case (int_osc_divider_field)
      clock_ctrl_pkg::DIV_BY_8: div_mask = 3'h7;
      clock_ctrl_pkg::DIV_BY_4: div_mask = 3'h3;
      clock_ctrl_pkg::DIV_BY_2: div_mask = 3'h1;
      default: div_mask = 3'h0;
    endcase
    next_int_cnt = int_osc_tick ? int_cnt + 3'h1 : int_cnt;
    int_sys = int_osc_tick && ((int_cnt & div_mask) == div_mask);
    int_half = int_osc_tick && int_cnt[0];
    // register writes; unused bits dropped
    next_mode = wr_ext ? sfr_wdata[clock_ctrl_pkg::MODE_MSB:clock_ctrl_pkg::MODE_LSB] :
                ext_osc_mode_field;
    next_freq = wr_ext ? sfr_wdata[clock_ctrl_pkg::FREQ_MSB:0] : ext_drive_freq_code;
    next_csel = wr_sel ? sfr_wdata[clock_ctrl_pkg::SEL_MSB:0] : clk_sel;
    next_en = wr_mult ? sfr_wdata[clock_ctrl_pkg::MULT_EN_BIT] : mult_en;
    next_msel = wr_mult ? sfr_wdata[clock_ctrl_pkg::SEL_MSB:0] : mult_sel;
    // init is held at zero on the write that turns the multiplier on
    next_init = wr_mult ? (sfr_wdata[clock_ctrl_pkg::MULT_INIT_BIT] && mult_en) : mult_init;
    // multiplier input select
    unique case (mult_sel)
      clock_ctrl_pkg::MULT_IN_INT_HALF: mi = int_half;
      clock_ctrl_pkg::MULT_IN_EXT: mi = ext_tick;
      clock_ctrl_pkg::MULT_IN_EXT_HALF: mi = ext_tick && ext_half2;
      default: mi = 1'b0;
    endcase
    // input period measurement
    next_since = since;
    next_period = period;
    stable = (since + P_ONE) == period;
    if (mi)
    begin
      next_since = '0;
      next_period = since + P_ONE;
    end
    else if (since != '1)
      next_since = since + P_ONE;
    // lock sequence
    next_locked = mult_locked;
    next_init_run = init_run;
    next_lock_cnt = lock_cnt;
    if (!mult_en)
    begin
      next_locked = 1'b0;
      next_init_run = 1'b0;
    end
    else if (wr_mult && next_init && next_en)
    begin
      next_locked = 1'b0;
      next_init_run = 1'b1;
      next_lock_cnt = 3'h0;
    end
    else if (init_run && mi)
    begin
      next_lock_cnt = stable ? lock_cnt + 3'h1 : 3'h0;
      if (stable && (lock_cnt == clock_ctrl_pkg::LOCK_PERIODS - 3'h1))
      begin
        next_locked = 1'b1;
        next_init_run = 1'b0;
      end
    end
    // four output pulses per input period
    quarter = period >> clock_ctrl_pkg::MULT_SHIFT;
    if (quarter == '0)
      quarter = P_ONE;
    next_mtick = 1'b0;
    next_out_cnt = out_cnt + P_ONE;
    next_sub = sub;
    if (mi && mult_locked)
    begin
      next_mtick = 1'b1;
      next_out_cnt = '0;
      next_sub = 2'h1;
    end
    else if (mult_locked && (sub != 2'h0) && (out_cnt + P_ONE == quarter))
    begin
      next_mtick = 1'b1;
      next_out_cnt = '0;
      next_sub = sub + 2'h1;
    end
    // glitch-free source switch
    next_sw = sw_state;
    next_cur = cur_sel;
    next_pend = pend_sel;
    next_sys = 1'b0;
    unique case (sw_state)
      clock_ctrl_pkg::SW_RUN:
      begin
        next_sys = src_tick(cur_sel, int_sys, ext_tick, next_mtick);
        if ((clk_sel != cur_sel) && (clk_sel != clock_ctrl_pkg::SRC_RESERVED))
        begin
          next_pend = clk_sel;
          next_sw = clock_ctrl_pkg::SW_OLD;
        end
      end
      clock_ctrl_pkg::SW_OLD:
      begin
        next_sys = src_tick(cur_sel, int_sys, ext_tick, next_mtick);
        if (next_sys)
          next_sw = clock_ctrl_pkg::SW_NEW;
      end
      clock_ctrl_pkg::SW_NEW:
      begin
        next_sys = src_tick(pend_sel, int_sys, ext_tick, next_mtick);
        if (next_sys)
        begin
          next_cur = pend_sel;
          next_sw = clock_ctrl_pkg::SW_RUN;
        end
      end
      default:
        next_sw = clock_ctrl_pkg::SW_RUN;
    endcase
    // register reads; unmapped reads zero
    next_rdata = sfr_rdata;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        clock_ctrl_pkg::ADDR_EXT_OSC:
          next_rdata = {crys_lvl && (ext_osc_mode_field[2:1] == 2'h3), ext_osc_mode_field,
                        1'b0, ext_drive_freq_code};
        clock_ctrl_pkg::ADDR_CLK_MULT:
          next_rdata = {mult_en, mult_init, mult_locked, 3'h0, mult_sel};
        clock_ctrl_pkg::ADDR_CLK_SELECT:
          next_rdata = {6'h00, clk_sel};
        default:
          next_rdata = clock_ctrl_pkg::REG_RESET;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // state registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_sync <= 3'h0;
      crys_sync <= 3'h0;
      ext_lvl <= 1'b0;
      crys_lvl <= 1'b0;
      ext_half <= 1'b0;
      ext_half2 <= 1'b0;
      int_cnt <= 3'h0;
      ext_osc_mode_field <= 3'h0;
      ext_drive_freq_code <= 3'h0;
      clk_sel <= clock_ctrl_pkg::SRC_INT;
      cur_sel <= clock_ctrl_pkg::SRC_INT;
      pend_sel <= clock_ctrl_pkg::SRC_INT;
      mult_en <= 1'b0;
      mult_init <= 1'b0;
      mult_sel <= 2'h0;
      mult_locked <= 1'b0;
      init_run <= 1'b0;
      lock_cnt <= 3'h0;
      since <= '0;
      period <= '0;
      out_cnt <= '0;
      sub <= 2'h0;
      sw_state <= clock_ctrl_pkg::SW_RUN;
      sysclk_tick <= 1'b0;
      periph_ext_tick <= 1'b0;
      mult_tick <= 1'b0;
      sfr_rdata <= clock_ctrl_pkg::REG_RESET;
    end
    else
    begin
      ext_sync <= next_ext_sync;
      crys_sync <= next_crys_sync;
      ext_lvl <= next_ext_lvl;
      crys_lvl <= next_crys_lvl;
      ext_half <= next_ext_half;
      ext_half2 <= next_ext_half2;
      int_cnt <= next_int_cnt;
      ext_osc_mode_field <= next_mode;
      ext_drive_freq_code <= next_freq;
      clk_sel <= next_csel;
      cur_sel <= next_cur;
      pend_sel <= next_pend;
      mult_en <= next_en;
      mult_init <= next_init;
      mult_sel <= next_msel;
      mult_locked <= next_locked;
      init_run <= next_init_run;
      lock_cnt <= next_lock_cnt;
      since <= next_since;
      period <= next_period;
      out_cnt <= next_out_cnt;
      sub <= next_sub;
      sw_state <= next_sw;
      sysclk_tick <= next_sys;
      periph_ext_tick <= next_periph;
      mult_tick <= next_mtick;
      sfr_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_xtal_valid_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_rd && sfr_addr == clock_ctrl_pkg::ADDR_EXT_OSC && ext_osc_mode_field[2:1] != 2'h3)
    |=> !sfr_rdata[clock_ctrl_pkg::XTAL_VALID_BIT])
    else $error("crystal valid read high outside crystal mode");
  a_freq_code_store: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_ext |=> (ext_drive_freq_code == $past(sfr_wdata[clock_ctrl_pkg::FREQ_MSB:0]))
    ##1 ($past(wr_ext) || $stable(ext_drive_freq_code)))
    else $error("frequency code not stored");
  a_sel_unused_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_rd && sfr_addr == clock_ctrl_pkg::ADDR_CLK_SELECT) |=> (sfr_rdata[7:2] == 6'h00))
    else $error("clock select unused bits not zero");
  a_init_on_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_mult && !mult_en) |=> !mult_init)
    else $error("init set on enabling write");
  a_init_drops_lock: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_mult && mult_en && sfr_wdata[clock_ctrl_pkg::MULT_INIT_BIT]
     && sfr_wdata[clock_ctrl_pkg::MULT_EN_BIT]) |=> (!mult_locked && init_run))
    else $error("init did not restart lock");
  a_disable_unlock: assert property (@(posedge sys_clk) disable iff (!resetn)
    !mult_en |=> !mult_locked)
    else $error("locked while disabled");
  a_mult_first_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mi && mult_locked) |=> mult_tick)
    else $error("multiplier missed aligned pulse");
  a_periph_ext_free: assert property (@(posedge sys_clk) disable iff (!resetn)
    ext_tick |=> periph_ext_tick)
    else $error("timer clock lost");
  a_int_immediate: assert property (@(posedge sys_clk) disable iff (!resetn)
    (int_osc_tick && int_osc_divider_field == 2'h3 && cur_sel == clock_ctrl_pkg::SRC_INT
     && sw_state != clock_ctrl_pkg::SW_NEW) |=> sysclk_tick)
    else $error("internal clock not passed");
  a_switch_no_runt: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sw_state == clock_ctrl_pkg::SW_NEW && !src_tick(pend_sel, int_sys, ext_tick, next_mtick))
    |=> !sysclk_tick)
    else $error("pulse during handover");

endmodule

`default_nettype wire

// ==== tb/ext_osc_mult_sysclk_select_tb.sv ====
// bench for the clock control block: register rows, multiplier, source switch
// assumes core/clock_ctrl_pkg.sv and core/clock_ctrl.sv are compiled first
`timescale 1ns/100ps
`default_nettype none

module ext_osc_mult_sysclk_select_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic int_osc_tick = 1'b0;
  logic [1:0] int_osc_divider_field = 2'h3;
  logic ext_osc_pin = 1'b0;
  logic crystal_ok_pin = 1'b0;
  logic [2:0] ext_osc_mode_field;
  logic [2:0] ext_drive_freq_code;
  logic sysclk_tick;
  logic periph_ext_tick;
  logic mult_tick;
  int fail_count = 0;
  int tests_run = 0;
  int c_sys;
  int c_per;
  int c_mul;
  int osc_cnt = 0;
  logic [7:0] rd_val;
  logic [7:0] r_addr [7] = '{8'hA9, 8'hA9, 8'hB1, 8'hB1, 8'hBE, 8'hBE, 8'h55};
  logic [7:0] r_wdat [7] = '{8'hFF, 8'h00, 8'hFF, 8'h2D, 8'h1F, 8'h00, 8'hFF};
  logic [7:0] r_exp [7] = '{8'h03, 8'h00, 8'h77, 8'h25, 8'h03, 8'h00, 8'h00};
  logic [1:0] m_sel [3] = '{2'h1, 2'h2, 2'h0};
  int m_exp [3] = '{64, 32, 80};
  logic [1:0] s_sel [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  int s_exp [4] = '{80, 16, 16, 40};
  int d_exp [4] = '{4, 8, 16, 32};
  logic [7:0] e_mode [6] = '{8'h20, 8'h30, 8'h00, 8'h77, 8'h15, 8'h45};
  int e_exp [6] = '{10, 5, 0, 5, 0, 10};

  // ------------------------------------------------------------
  // clock, oscillator stimulus, design
  // ------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;

  // internal pulse every 8 cycles, external level flips every 10
  always @(posedge sys_clk)
  begin
    #10;
    osc_cnt = osc_cnt + 1;
    int_osc_tick = (osc_cnt % 8 == 0);
    if (osc_cnt % 10 == 0)
      ext_osc_pin = ~ext_osc_pin;
  end

  clock_ctrl clock_ctrl_inst
  (
    .sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_osc_tick(int_osc_tick), .int_osc_divider_field(int_osc_divider_field),
    .ext_osc_pin(ext_osc_pin), .crystal_ok_pin(crystal_ok_pin),
    .ext_osc_mode_field(ext_osc_mode_field), .ext_drive_freq_code(ext_drive_freq_code),
    .sysclk_tick(sysclk_tick), .periph_ext_tick(periph_ext_tick), .mult_tick(mult_tick)
  );

  // ------------------------------------------------------------
  // bus cycles, compares, counting
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #10;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #10;
    sfr_wr = 1'b0;
  endtask

  // data lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    #10;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge sys_clk);
    #10;
    sfr_rd = 1'b0;
    rd_val = sfr_rdata;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      fail_count++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask

  // settle, then count output pulses over n cycles; an unknown counts as a pulse
  task automatic count(input int n);
    c_sys = 0;
    c_per = 0;
    c_mul = 0;
    repeat (100) @(posedge sys_clk);
    repeat (n)
    begin
      @(posedge sys_clk);
      #10;
      c_sys += int'(sysclk_tick !== 1'b0);
      c_per += int'(periph_ext_tick !== 1'b0);
      c_mul += int'(mult_tick !== 1'b0);
    end
  endtask

  task automatic test_done;
    $display("tests run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reset;
    rd(8'hA9);
    check_byte(rd_val, 8'h00);
    rd(8'hB1);
    check_byte(rd_val, 8'h00);
    rd(8'hBE);
    check_byte(rd_val, 8'h00);
    check_byte({2'h0, ext_osc_mode_field, ext_drive_freq_code}, 8'h00);
  endtask

  // clear, select, enable, wait over 5 us, initialize
  task automatic mult_up(input logic [1:0] s);
    wr(8'hBE, 8'h00);
    wr(8'hBE, {6'h00, s});
    wr(8'hBE, {6'h20, s});
    rd(8'hBE);
    check_byte(rd_val, {6'h20, s});
    repeat (60) @(posedge sys_clk);
    wr(8'hBE, {6'h30, s});
  endtask

  task automatic poll_lock;
    int k;
    k = 0;
    rd(8'hBE);
    while (rd_val[5] !== 1'b1 && k < 100)
    begin
      rd(8'hBE);
      k++;
    end
    if (k >= 100)
    begin
      fail_count++;
      $display("unexpected at %0t: multiplier never locked", $time);
      test_done();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #10;
    resetn = 1'b1;
    chk_reset();
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      wr(r_addr[i], r_wdat[i]);
      rd(r_addr[i]);
      check_byte(rd_val, r_exp[i]);
    end
    check_byte({2'h0, ext_osc_mode_field, ext_drive_freq_code}, 8'h15);
    $display("test register rows done");
    // crystal valid flag follows the detector only in crystal modes
    wr(8'hB1, 8'h67);
    // crystal settle time of at least 1 ms before the flag is read
    repeat (10000) @(posedge sys_clk);
    rd(8'hB1);
    check_byte(rd_val, 8'h67);
    crystal_ok_pin = 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(8'hB1);
    check_byte(rd_val, 8'hE7);
    wr(8'hB1, 8'h45);
    rd(8'hB1);
    check_byte(rd_val, 8'h45);
    crystal_ok_pin = 1'b0;
    $display("test crystal flag done");
    // external clock reaches timers while internal drives the system
    for (int i = 0; i < 6; i++)
    begin
      wr(8'hB1, e_mode[i]);
      count(200);
      check_count(c_per, e_exp[i]);
      check_count(c_sys, 25);
    end
    wr(8'hB1, 8'h20);
    $display("test external timer clock done");
    // enabling write keeps initialize clear; reserved input never locks
    wr(8'hBE, 8'h00);
    wr(8'hBE, 8'hC1);
    rd(8'hBE);
    check_byte(rd_val, 8'h81);
    mult_up(2'h3);
    count(100);
    check_count(c_mul, 0);
    rd(8'hBE);
    check_byte(rd_val, 8'hC3);
    $display("test multiplier refusals done");
    for (int i = 0; i < 3; i++)
    begin
      mult_up(m_sel[i]);
      poll_lock();
      count(320);
      check_count(c_mul, m_exp[i]);
    end
    $display("test multiplier inputs done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hA9, {6'h00, s_sel[i]});
      count(320);
      check_count(c_sys, s_exp[i]);
    end
    $display("test source switch done");
    for (int i = 0; i < 4; i++)
    begin
      int_osc_divider_field = i[1:0];
      count(256);
      check_count(c_sys, d_exp[i]);
    end
    $display("test divider done");
    wr(8'hBE, 8'h00);
    count(100);
    check_count(c_mul, 0);
    rd(8'hBE);
    check_byte(rd_val, 8'h00);
    $display("test multiplier disable done");
    // second reset in mid-run
    wr(8'hB1, 8'h67);
    @(posedge sys_clk);
    #10;
    resetn = 1'b0;
    repeat (8) @(posedge sys_clk);
    #10;
    resetn = 1'b1;
    chk_reset();
    $display("test mid-run reset done");
    test_done();
  end
endmodule

`default_nettype wire
